// >>> rtl/eeau_top.sv
`timescale 1ns/1ps
`default_nettype none

module eeau_top #(
  parameter int unsigned WRITE_CYCLES = eeau_pkg::WRITE_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ext_reset_i,
  input  wire logic        wdt_reset_i,
  input  wire logic [11:0] awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [11:0] araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic        prog_req_i,
  input  wire logic        prog_we_i,
  input  wire logic [7:0]  prog_addr_i,
  input  wire logic [7:0]  prog_wdata_i,
  output logic             prog_ready_o,
  output logic             prog_valid_o,
  output logic [7:0]       prog_rdata_o,
  output logic             irq_o
);

  localparam logic [19:0] HALF = 20'(WRITE_CYCLES / 2);

  typedef struct packed {
    eeau_pkg::eeau_st_t st;
    logic [19:0]        tmr;
    logic [7:0]         data;
    logic [7:0]         addr;
    logic               rd;
    logic               wr;
    logic               permit;
    logic               abort;
    logic [1:0]         unlk;
    logic [1:0]         istat;
    logic [1:0]         imask;
    logic               protect;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic               prog_q;
    logic               prog_valid;
    logic [7:0]         prog_rdata;
  } eeau_state_t;

  eeau_state_t          s_ff;
  eeau_state_t          nxt_s;
  eeau_pkg::eeau_mreq_t req;
  logic [7:0]           mem_rdata;
  logic                 wr_take;
  logic                 abort_ev;
  logic [7:0]           widx;
  logic [7:0]           ridx;
  logic [7:0]           wd;

  eeau_mem eeau_mem_i (
    .mclk_i  (mclk_i),
    .req_i   (req),
    .rdata_o (mem_rdata)
  );

  assign widx     = awaddr_i[9:2];
  assign ridx     = araddr_i[9:2];
  assign wd       = wdata_i[7:0];
  assign wr_take  = awvalid_i & wvalid_i & ~s_ff.bvalid;
  assign abort_ev = ext_reset_i | wdt_reset_i;

  // Whole next-state computation: bus slave, triggers, timer, programmer.
  always_comb begin
    nxt_s        = s_ff;
    req          = '0;
    prog_ready_o = 1'b0;
    nxt_s.bvalid = s_ff.bvalid & ~bready_i;
    nxt_s.rvalid = s_ff.rvalid & ~rready_i;
    nxt_s.prog_q = 1'b0;
    nxt_s.prog_valid = 1'b0;
    // The read launched last cycle lands in the data register now.
    if (s_ff.rd) begin
      nxt_s.data = mem_rdata;
      nxt_s.rd   = 1'b0;
    end
    // Programmer read result, blanked while protection is on.
    if (s_ff.prog_q) begin
      nxt_s.prog_valid = 1'b1;
      nxt_s.prog_rdata = s_ff.protect ? 8'h00 : mem_rdata;
    end
    // Register read channel; the unlock address reads zero.
    if (arvalid_i && !s_ff.rvalid) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = eeau_pkg::RESP_OKAY;
      nxt_s.rdata  = 32'h0000_0000;
      if (araddr_i[11:10] != 2'h0) begin
        nxt_s.rresp = eeau_pkg::RESP_SLVERR;
      end else begin
        case (ridx)
          eeau_pkg::IDX_DATA: nxt_s.rdata[7:0] = s_ff.data;
          eeau_pkg::IDX_ADDR: nxt_s.rdata[7:0] = s_ff.addr;
          eeau_pkg::IDX_CTRL: begin
            nxt_s.rdata[eeau_pkg::CTRL_RD_BIT]     = s_ff.rd;
            nxt_s.rdata[eeau_pkg::CTRL_WR_BIT]     = s_ff.wr;
            nxt_s.rdata[eeau_pkg::CTRL_PERMIT_BIT] = s_ff.permit;
            nxt_s.rdata[eeau_pkg::CTRL_ABORT_BIT]  = s_ff.abort;
          end
          eeau_pkg::IDX_UNLK: nxt_s.rdata = 32'h0000_0000;
          eeau_pkg::IDX_STAT: nxt_s.rdata[1:0] = s_ff.istat;
          eeau_pkg::IDX_MASK: nxt_s.rdata[1:0] = s_ff.imask;
          eeau_pkg::IDX_CFG:
            nxt_s.rdata[eeau_pkg::CFG_PROTECT_BIT] = s_ff.protect;
          default: nxt_s.rresp = eeau_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Register write channel; address and data are taken together.
    if (wr_take) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = eeau_pkg::RESP_OKAY;
      if (awaddr_i[11:10] != 2'h0) begin
        nxt_s.bresp = eeau_pkg::RESP_SLVERR;
      end else begin
        case (widx)
          eeau_pkg::IDX_DATA: begin
            if (wstrb_i[0] && !s_ff.wr) begin
              nxt_s.data = wd;
            end
          end
          eeau_pkg::IDX_ADDR: begin
            if (wstrb_i[0] && !s_ff.wr) begin
              nxt_s.addr = wd;
            end
          end
          eeau_pkg::IDX_CTRL: begin
            if (wstrb_i[0]) begin
              nxt_s.permit = wd[eeau_pkg::CTRL_PERMIT_BIT];
              nxt_s.abort  = wd[eeau_pkg::CTRL_ABORT_BIT];
              nxt_s.unlk   = 2'h0;
              // Zeros in the trigger bits change nothing.
              if (wd[eeau_pkg::CTRL_RD_BIT] && !s_ff.wr) begin
                nxt_s.rd = 1'b1;
                req.re   = 1'b1;
                req.addr = s_ff.addr;
              end else if (wd[eeau_pkg::CTRL_WR_BIT] && !s_ff.wr &&
                           wd[eeau_pkg::CTRL_PERMIT_BIT] &&
                           s_ff.unlk == 2'h2) begin
                // Protection gates the programmer port, never this path.
                nxt_s.wr  = 1'b1;
                nxt_s.st  = eeau_pkg::ST_ERASE;
                nxt_s.tmr = HALF - 20'h1;
                req.we    = 1'b1;
                req.addr  = s_ff.addr;
                req.wdata = eeau_pkg::ERASED_BYTE;
              end
            end
          end
          // The key pair arms one write and is kept nowhere else.
          eeau_pkg::IDX_UNLK: begin
            if (wstrb_i[0] && wd == eeau_pkg::UNLOCK_KEY1) begin
              nxt_s.unlk = 2'h1;
            end else if (wstrb_i[0] && wd == eeau_pkg::UNLOCK_KEY2 &&
                         s_ff.unlk == 2'h1) begin
              nxt_s.unlk = 2'h2;
            end else begin
              nxt_s.unlk = 2'h0;
            end
          end
          eeau_pkg::IDX_STAT: begin
            if (wstrb_i[0]) begin
              nxt_s.istat = s_ff.istat & ~wd[1:0];
            end
          end
          eeau_pkg::IDX_MASK: begin
            if (wstrb_i[0]) begin
              nxt_s.imask = wd[1:0];
            end
          end
          eeau_pkg::IDX_CFG: begin
            if (wstrb_i[0]) begin
              nxt_s.protect = wd[eeau_pkg::CFG_PROTECT_BIT];
            end
          end
          default: nxt_s.bresp = eeau_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Self-timed write: erase half, then program half.
    case (s_ff.st)
      eeau_pkg::ST_IDLE: begin
      end
      eeau_pkg::ST_ERASE: begin
        if (s_ff.tmr == 20'h0) begin
          nxt_s.st  = eeau_pkg::ST_PROG;
          nxt_s.tmr = HALF - 20'h1;
          req.we    = 1'b1;
          req.addr  = s_ff.addr;
          req.wdata = s_ff.data;
        end else begin
          nxt_s.tmr = s_ff.tmr - 20'h1;
        end
      end
      eeau_pkg::ST_PROG: begin
        if (s_ff.tmr == 20'h0) begin
          nxt_s.st = eeau_pkg::ST_IDLE;
          nxt_s.wr = 1'b0;
          nxt_s.istat[eeau_pkg::IRQ_DONE_BIT] = 1'b1;
        end else begin
          nxt_s.tmr = s_ff.tmr - 20'h1;
        end
      end
      default: nxt_s.st = eeau_pkg::ST_IDLE;
    endcase
    // Programmer port, only while the array is otherwise idle.
    if (s_ff.st == eeau_pkg::ST_IDLE && !req.we && !req.re) begin
      prog_ready_o = 1'b1;
      if (prog_req_i) begin
        req.addr = prog_addr_i;
        if (prog_we_i) begin
          req.we    = ~s_ff.protect;
          req.wdata = prog_wdata_i;
        end else begin
          req.re       = ~s_ff.protect;
          nxt_s.prog_q = 1'b1;
        end
      end
    end
    // Pin or watchdog reset: a write in flight is aborted and flagged.
    if (abort_ev) begin
      if (s_ff.wr) begin
        nxt_s.abort = 1'b1;
        nxt_s.istat[eeau_pkg::IRQ_ABORT_BIT] = 1'b1;
        nxt_s.data  = eeau_pkg::DATA_RST;
        nxt_s.addr  = eeau_pkg::ADDR_RST;
        if (s_ff.st != eeau_pkg::ST_IDLE) begin
          req.we = 1'b0;
        end
      end
      nxt_s.wr     = 1'b0;
      nxt_s.rd     = 1'b0;
      nxt_s.permit = 1'b0;
      nxt_s.unlk   = 2'h0;
      nxt_s.st     = eeau_pkg::ST_IDLE;
    end
  end

  // Power-on reset clears every register except the state, which loads ST_IDLE; the protect setting is off.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_ff      <= '0;
      s_ff.st   <= eeau_pkg::ST_IDLE;
      s_ff.data <= eeau_pkg::DATA_RST;
      s_ff.addr <= eeau_pkg::ADDR_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready_o    = wr_take;
  assign wready_o     = wr_take;
  assign bvalid_o     = s_ff.bvalid;
  assign bresp_o      = s_ff.bresp;
  assign arready_o    = ~s_ff.rvalid;
  assign rvalid_o     = s_ff.rvalid;
  assign rresp_o      = s_ff.rresp;
  assign rdata_o      = s_ff.rdata;
  assign prog_valid_o = s_ff.prog_valid;
  assign prog_rdata_o = s_ff.prog_rdata;
  assign irq_o        = |(s_ff.istat & s_ff.imask);

  // Helper count of cycles the write trigger has been high.
  logic [19:0] wr_cnt_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !s_ff.wr) begin
      wr_cnt_ff <= 20'h0;
    end else begin
      wr_cnt_ff <= wr_cnt_ff + 20'h1;
    end
  end

  // Checks on the block's own behaviour.
  a_read_lands:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(s_ff.rd) && !abort_ev |=> !s_ff.rd &&
      s_ff.data == $past(mem_rdata))
    else $error("Read trigger did not load data in one cycle.");
  a_write_permit:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(s_ff.wr) |-> s_ff.permit && $past(s_ff.unlk) == 2'h2)
    else $error("Write started without permit or unlock.");
  a_write_length:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(s_ff.wr) && !$past(abort_ev) |->
      wr_cnt_ff == 2 * HALF && $past(wr_cnt_ff) == 2 * HALF - 20'h1)
    else $error("Write length differs from the timer setting.");
  a_erase_first:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      req.we && s_ff.st == eeau_pkg::ST_IDLE && !s_ff.wr &&
      !prog_req_i |-> req.wdata == eeau_pkg::ERASED_BYTE)
    else $error("Write did not begin with an erase.");
  a_done_flag:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      s_ff.st == eeau_pkg::ST_PROG && s_ff.tmr == 20'h0 && !abort_ev
      |=> s_ff.istat[eeau_pkg::IRQ_DONE_BIT] && !s_ff.wr)
    else $error("Done flag not set at write end.");
  a_wr_held:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      s_ff.wr && !abort_ev && !(s_ff.st == eeau_pkg::ST_PROG &&
      s_ff.tmr == 20'h0) |=> s_ff.wr)
    else $error("Write trigger cleared early.");
  a_abort_clears:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      abort_ev && s_ff.wr |=> s_ff.abort && s_ff.addr == 8'h00 &&
      s_ff.data == 8'h00 && s_ff.st == eeau_pkg::ST_IDLE)
    else $error("Aborted write not flagged and cleared.");
  a_prog_blank:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      prog_req_i && prog_ready_o && s_ff.protect && !prog_we_i |->
      !req.re ##1 1'b1 ##1 prog_valid_o && prog_rdata_o == 8'h00)
    else $error("Protected programmer read not blanked.");
  a_unlock_zero:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      arvalid_i && arready_o && araddr_i == {2'h0, eeau_pkg::IDX_UNLK,
      2'h0} |=> rvalid_o && rdata_o == 32'h0000_0000)
    else $error("Unlock register read not zero.");

  c_write_done:
    cover property (@(posedge mclk_i) disable iff (rst_i)
      $fell(s_ff.wr) && s_ff.istat[eeau_pkg::IRQ_DONE_BIT]);
  c_read:
    cover property (@(posedge mclk_i) disable iff (rst_i) $fell(s_ff.rd));
  c_abort:
    cover property (@(posedge mclk_i) disable iff (rst_i)
      abort_ev && s_ff.wr);
  c_prog_read:
    cover property (@(posedge mclk_i) disable iff (rst_i) prog_valid_o);

endmodule

`default_nettype wire

// >>> rtl/eeau_pkg.sv
package eeau_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_DATA = 8'h9a;
  localparam logic [7:0] IDX_ADDR = 8'h9b;
  localparam logic [7:0] IDX_CTRL = 8'h9c;
  localparam logic [7:0] IDX_UNLK = 8'h9d;
  localparam logic [7:0] IDX_STAT = 8'ha0;
  localparam logic [7:0] IDX_MASK = 8'ha1;
  localparam logic [7:0] IDX_CFG  = 8'ha2;

  // Control register field positions.
  localparam int CTRL_RD_BIT     = 0;
  localparam int CTRL_WR_BIT     = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_ABORT_BIT  = 3;

  // Interrupt status and mask field positions.
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ABORT_BIT = 1;

  // Configuration field position.
  localparam int CFG_PROTECT_BIT = 0;

  // Reset values.
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // Unlock key sequence and the erased cell value.
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: the self-timed write covers erase and program halves.
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG  = 3'b100
  } eeau_st_t;

  // One access to the cell array.
  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eeau_mreq_t;

endpackage

// >>> rtl/eeau_mem.sv
`timescale 1ns/1ps
`default_nettype none

module eeau_mem (
  input  wire logic                mclk_i,
  input  wire eeau_pkg::eeau_mreq_t req_i,
  output logic [7:0]               rdata_o
);

  typedef struct packed {
    logic [7:0] rdata;
  } eeau_mem_st_t;

  logic [7:0]   cells [0:255];
  eeau_mem_st_t s_ff;
  eeau_mem_st_t nxt_s;

  // Read data update only on a read request and come from a register.
  always_comb begin
    nxt_s = s_ff;
    if (req_i.re) begin
      nxt_s.rdata = cells[req_i.addr];
    end
  end

  always_ff @(posedge mclk_i) begin
    s_ff <= nxt_s;
  end

  // The cell array keeps its contents across resets, as storage should.
  always_ff @(posedge mclk_i) begin
    if (req_i.we) begin
      cells[req_i.addr] <= req_i.wdata;
    end
  end

  assign rdata_o = s_ff.rdata;

endmodule

`default_nettype wire

// >>> rtl/eeau_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bench/eeau_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module eeau_top_tb;
  localparam int WC = 20;
  logic        mclk_i       = 1'b0;
  logic        rst_i        = 1'b1;
  logic        ext_reset_i  = 1'b0;
  logic        wdt_reset_i  = 1'b0;
  logic [11:0] awaddr_i     = 12'h000;
  logic        awvalid_i    = 1'b0;
  logic [31:0] wdata_i      = 32'h00000000;
  logic [3:0]  wstrb_i      = 4'h0;
  logic        wvalid_i     = 1'b0;
  logic        bready_i     = 1'b0;
  logic [11:0] araddr_i     = 12'h000;
  logic        arvalid_i    = 1'b0;
  logic        rready_i     = 1'b0;
  logic        prog_req_i   = 1'b0;
  logic        prog_we_i    = 1'b0;
  logic [7:0]  prog_addr_i  = 8'h00;
  logic [7:0]  prog_wdata_i = 8'h00;
  logic        awready_o;
  logic        wready_o;
  logic [1:0]  bresp_o;
  logic        bvalid_o;
  logic        arready_o;
  logic [31:0] rdata_o;
  logic [1:0]  rresp_o;
  logic        rvalid_o;
  logic        prog_ready_o;
  logic        prog_valid_o;
  logic [7:0]  prog_rdata_o;
  logic        irq_o;
  logic [1:0]  wresp;
  logic [1:0]  rresp;
  logic [31:0] rdat;
  logic [7:0]  pdat;
  int          failures     = 0;
  int          n_checks     = 0;
  int          cyc          = 0;
  int          t0;
  logic [7:0]  addrs [2]    = '{8'h00, 8'hff};
  logic [7:0]  vals  [2]    = '{8'h3c, 8'hc3};

  eeau_top #(.WRITE_CYCLES(WC)) eeau_top_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .ext_reset_i(ext_reset_i),
    .wdt_reset_i(wdt_reset_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
    .prog_req_i(prog_req_i), .prog_we_i(prog_we_i),
    .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i),
    .prog_ready_o(prog_ready_o), .prog_valid_o(prog_valid_o),
    .prog_rdata_o(prog_rdata_o), .irq_o(irq_o)
  );

  // The clock toggles every half period of 50 ns and cycles are counted.
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares a word and counts the outcome.
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares a single flag and counts the outcome.
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write: both channels offered together, held until taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge mclk_i);
    awaddr_i  <= {2'b00, idx, 2'b00};
    awvalid_i <= 1'b1;
    wdata_i   <= {24'h000000, val};
    wstrb_i   <= 4'hf;
    wvalid_i  <= 1'b1;
    bready_i  <= 1'b1;
    do @(posedge mclk_i); while (!(awready_o === 1'b1 && wready_o === 1'b1));
    awvalid_i <= 1'b0;
    wvalid_i  <= 1'b0;
    do @(posedge mclk_i); while (bvalid_o !== 1'b1);
    wresp = bresp_o;
    bready_i <= 1'b0;
  endtask

  // Bus read: address held until taken, data captured with rvalid.
  task automatic rd(input logic [7:0] idx);
    @(posedge mclk_i);
    araddr_i  <= {2'b00, idx, 2'b00};
    arvalid_i <= 1'b1;
    rready_i  <= 1'b1;
    do @(posedge mclk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    while (rvalid_o !== 1'b1) @(posedge mclk_i);
    rdat  = rdata_o;
    rresp = rresp_o;
    rready_i <= 1'b0;
  endtask

  // Programmer access; a read waits for the valid pulse.
  task automatic prog(input logic       we,
                      input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge mclk_i);
    prog_req_i   <= 1'b1;
    prog_we_i    <= we;
    prog_addr_i  <= a;
    prog_wdata_i <= d;
    do @(posedge mclk_i); while (prog_ready_o !== 1'b1);
    prog_req_i <= 1'b0;
    if (!we) begin
      do @(posedge mclk_i); while (prog_valid_o !== 1'b1);
      pdat = prog_rdata_o;
    end
  endtask

  // Starts a self-timed byte write through the unlock sequence.
  task automatic nv_write(input logic [7:0] a, input logic [7:0] v);
    wr(eeau_pkg::IDX_DATA, v);
    wr(eeau_pkg::IDX_ADDR, a);
    wr(eeau_pkg::IDX_UNLK, eeau_pkg::UNLOCK_KEY1);
    wr(eeau_pkg::IDX_UNLK, eeau_pkg::UNLOCK_KEY2);
    t0 = cyc;
    wr(eeau_pkg::IDX_CTRL, 8'h06);
  endtask

  // Fetches one location into the data register and reads it out.
  task automatic nv_read(input logic [7:0] a);
    wr(eeau_pkg::IDX_ADDR, a);
    wr(eeau_pkg::IDX_CTRL, 8'h01);
    rd(eeau_pkg::IDX_DATA);
  endtask

  // Polls the write trigger until it clears.
  task automatic poll_done();
    do rd(eeau_pkg::IDX_CTRL); while (rdat[1] === 1'b1);
  endtask

  // The watchdog ends a hung run as a failure.
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    final_report();
  end

  // Main test sequence.
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(eeau_pkg::IDX_DATA);
    chk_val(rdat, 32'h00000000);
    rd(eeau_pkg::IDX_ADDR);
    chk_val(rdat, 32'h00000000);
    wr(eeau_pkg::IDX_UNLK, 8'h5a);
    rd(eeau_pkg::IDX_UNLK);
    chk_val(rdat, 32'h00000000);
    rd(8'h00);
    chk_val({30'h0, rresp}, {30'h0, eeau_pkg::RESP_SLVERR});
    wr(8'h00, 8'h00);
    chk_val({30'h0, wresp}, {30'h0, eeau_pkg::RESP_SLVERR});
    wr(eeau_pkg::IDX_DATA, 8'ha5);
    chk_val({30'h0, wresp}, {30'h0, eeau_pkg::RESP_OKAY});
    rd(eeau_pkg::IDX_DATA);
    chk_val(rdat, 32'h000000a5);
    wr(eeau_pkg::IDX_ADDR, 8'h5a);
    rd(eeau_pkg::IDX_ADDR);
    chk_val(rdat, 32'h0000005a);
    // Writes at both ends of the address range, then reads them back.
    for (int i = 0; i < 2; i++) begin
      nv_write(addrs[i], vals[i]);
      wr(eeau_pkg::IDX_CTRL, 8'h00);
      wr(eeau_pkg::IDX_DATA, 8'h11);
      rd(eeau_pkg::IDX_CTRL);
      chk_bit(rdat[1], 1'b1);
      chk_bit(prog_ready_o, 1'b0);
      poll_done();
      chk_bit((cyc - t0) >= WC && (cyc - t0) <= WC + 12, 1'b1);
      rd(eeau_pkg::IDX_STAT);
      chk_val(rdat, 32'h00000001);
      chk_bit(irq_o, 1'b0);
      wr(eeau_pkg::IDX_MASK, 8'h01);
      chk_bit(irq_o, 1'b1);
      wr(eeau_pkg::IDX_STAT, 8'h01);
      chk_bit(irq_o, 1'b0);
      wr(eeau_pkg::IDX_MASK, 8'h00);
      nv_read(addrs[i]);
      chk_val(rdat, {24'h0, vals[i]});
      rd(eeau_pkg::IDX_CTRL);
      chk_bit(rdat[0], 1'b0);
    end
    // A trigger without permit, and one without unlock, are ignored.
    wr(eeau_pkg::IDX_UNLK, eeau_pkg::UNLOCK_KEY1);
    wr(eeau_pkg::IDX_UNLK, eeau_pkg::UNLOCK_KEY2);
    wr(eeau_pkg::IDX_CTRL, 8'h02);
    rd(eeau_pkg::IDX_CTRL);
    chk_bit(rdat[1], 1'b0);
    wr(eeau_pkg::IDX_CTRL, 8'h06);
    rd(eeau_pkg::IDX_CTRL);
    chk_bit(rdat[1], 1'b0);
    // Pin and watchdog resets cut a write short during its erase half.
    for (int i = 0; i < 2; i++) begin
      nv_write(8'h10, 8'h77);
      repeat (3) @(posedge mclk_i);
      ext_reset_i <= (i == 0);
      wdt_reset_i <= (i == 1);
      @(posedge mclk_i);
      ext_reset_i <= 1'b0;
      wdt_reset_i <= 1'b0;
      rd(eeau_pkg::IDX_CTRL);
      chk_val(rdat & 32'h0000000a, 32'h00000008);
      rd(eeau_pkg::IDX_DATA);
      chk_val(rdat, 32'h00000000);
      rd(eeau_pkg::IDX_ADDR);
      chk_val(rdat, 32'h00000000);
      rd(eeau_pkg::IDX_STAT);
      chk_val(rdat, 32'h00000002);
      wr(eeau_pkg::IDX_CTRL, 8'h00);
      wr(eeau_pkg::IDX_STAT, 8'h03);
      nv_read(8'h10);
      chk_val(rdat, {24'h0, eeau_pkg::ERASED_BYTE});
    end
    // The programmer sees data until protection is switched on.
    prog(1'b0, 8'hff, 8'h00);
    chk_val({24'h0, pdat}, 32'h000000c3);
    wr(eeau_pkg::IDX_CFG, 8'h01);
    prog(1'b0, 8'hff, 8'h00);
    chk_val({24'h0, pdat}, 32'h00000000);
    prog(1'b1, 8'hff, 8'h99);
    nv_read(8'hff);
    chk_val(rdat, 32'h000000c3);
    nv_write(8'h20, 8'h5e);
    poll_done();
    nv_read(8'h20);
    chk_val(rdat, 32'h0000005e);
    // A power-on reset in mid-run clears the registers, not the cells.
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(eeau_pkg::IDX_DATA);
    chk_val(rdat, 32'h00000000);
    nv_read(8'h20);
    chk_val(rdat, 32'h0000005e);
    final_report();
  end
endmodule

`default_nettype wire
